/* lamp_defs.svh */
// Contract
// - Green link lamp lights steadily while a port has a physical connection.
// - Yellow traffic lamp flashes while frames are received or sent on the port.
// - Red fault lamp stays dark when the interface and all I/O exchange are healthy.
// - Fault lamp lights steadily on bus fault: no link, wrong rate, no duplex. The code treats no link as a bus fault only when no port has a link.
// - Fault lamp flashes 2 Hz on device failure, unreachable device or bad configuration.
// - Sync lamp dark while unsynchronized or isochronous mode is not configured.
// - Configured but unsynchronized interface generates a local substitute cycle clock.
// - Sync lamp steady once interface, tasks, drive and fieldbus are all synchronized.
// - Sync lamp flashes 2 Hz when only interface and tasks are synchronized.
// - Without isochronous mode no send cycle synchronization happens and sync lamp stays off.
`ifndef LAMP_DEFS_SVH
`define LAMP_DEFS_SVH

// Clock and lamp timing.
`define CLK_HZ            100000000
`define FLASH_HZ          2
`define FLICKER_HZ        8
`define STRETCH_MS        100
`define FLASH_HALF_CYC    (`CLK_HZ / (2 * `FLASH_HZ))
`define FLICKER_HALF_CYC  (`CLK_HZ / (2 * `FLICKER_HZ))
`define STRETCH_CYC       ((`CLK_HZ / 1000) * `STRETCH_MS)

// Port count.
`define PORT_COUNT        2

// Register byte offsets.
`define OFS_CTRL          8'h00
`define OFS_CYCLE_LEN     8'h04
`define OFS_STATUS        8'h08
`define OFS_IRQ_STAT      8'h0C
`define OFS_IRQ_MASK      8'h10

// Field positions.
`define CTRL_ISO_BIT      0
`define EV_LINK_UP        0
`define EV_BUS_FAULT      1
`define EV_DEV_FAULT      2
`define EV_SYNC_FULL      3
`define EV_SYNC_LOST      4
`define EV_COUNT          5

// Reset values.
`define CTRL_RST          1'h0
`define CYCLE_LEN_RST     16'h0C35
`define IRQ_MASK_RST      5'h00

`endif

/* lamp_pkg.sv */
`include "lamp_defs.svh"

package lamp_pkg;

   // Register state of the lamp driver.
   typedef struct packed {
      logic                      hreadyout;
      logic [31:0]               hrdata;
      logic                      wr_pend;
      logic [7:0]                wr_addr;
      logic                      iso_cfg;
      logic [15:0]               cyc_len;
      logic [`EV_COUNT-1:0]      irq_stat;
      logic [`EV_COUNT-1:0]      irq_mask;
      logic                      irq;
      logic                      slow_ph;
      logic                      fast_ph;
      logic [`PORT_COUNT-1:0]    link_prev;
      logic                      bus_prev;
      logic                      dev_prev;
      logic                      full_prev;
      logic                      ifc_prev;
      logic [`PORT_COUNT-1:0]    link_lamp;
      logic [`PORT_COUNT-1:0]    traffic_lamp;
      logic                      fault_lamp;
      logic                      sync_lamp;
      logic [15:0]               cyc_cnt;
      logic                      cyc_tick;
      logic                      cyc_local;
   } lamp_state_t;

   // Divider and stretcher state.
   typedef struct packed {
      logic [31:0] cnt;
      logic        out;
   } count_state_t;

endpackage : lamp_pkg

/* flash_divider.sv */
`timescale 1ns/10ps

module flash_divider #(
   parameter int unsigned HALF_CYC = 32'd25000000
) (
   // Clock and reset.
   input  wire logic CLK,
   input  wire logic RST_N,
   // Half-period enable pulse.
   output logic      TICK
);

   lamp_pkg::count_state_t s_q;
   lamp_pkg::count_state_t s_d;

   // Counts one half period and pulses at its end, giving an even duty after toggling.
   always_comb begin
      s_d = s_q;
      s_d.out = 1'b0;
      if (s_q.cnt >= HALF_CYC - 32'd1) begin
         s_d.cnt = 32'h0000_0000;
         s_d.out = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 32'd1;
      end
   end

   // State register.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign TICK = s_q.out;

endmodule : flash_divider

/* activity_stretch.sv */
`timescale 1ns/10ps

module activity_stretch #(
   parameter int unsigned HOLD_CYC = 32'd10000000
) (
   // Clock and reset.
   input  wire logic CLK,
   input  wire logic RST_N,
   // Raw traffic level and stretched result.
   input  wire logic ACT_IN,
   output logic      BUSY
);

   lamp_pkg::count_state_t s_q;
   lamp_pkg::count_state_t s_d;

   // Reloads on every traffic cycle so one short frame stays visible for the hold time.
   always_comb begin
      s_d = s_q;
      if (ACT_IN) begin
         s_d.cnt = HOLD_CYC;
      end else if (s_q.cnt != 32'h0000_0000) begin
         s_d.cnt = s_q.cnt - 32'd1;
      end
      s_d.out = ACT_IN || (s_d.cnt != 32'h0000_0000);
   end

   // State register.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign BUSY = s_q.out;

endmodule : activity_stretch

/* port_status_lamps.sv */
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "lamp_defs.svh"

module port_status_lamps #(
   parameter int unsigned FLASH_HALF_CYC   = `FLASH_HALF_CYC,
   parameter int unsigned FLICKER_HALF_CYC = `FLICKER_HALF_CYC,
   parameter int unsigned STRETCH_CYC      = `STRETCH_CYC
) (
   // Clock and reset.
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   // AHB-Lite slave.
   input  wire logic                   HSEL,
   input  wire logic [31:0]            HADDR,
   input  wire logic [1:0]             HTRANS,
   input  wire logic                   HWRITE,
   input  wire logic [2:0]             HSIZE,
   input  wire logic [31:0]            HWDATA,
   input  wire logic                   HREADY,
   output logic      [31:0]            HRDATA,
   output logic                        HREADYOUT,
   output logic                        HRESP,
   // Port status.
   input  wire logic [`PORT_COUNT-1:0] PHY_LINK,
   input  wire logic [`PORT_COUNT-1:0] RX_ACTIVE,
   input  wire logic [`PORT_COUNT-1:0] TX_ACTIVE,
   input  wire logic                   RATE_OK,
   input  wire logic                   DUPLEX_OK,
   // Protocol status.
   input  wire logic                   DEV_FAILED,
   input  wire logic                   DEV_UNREACHABLE,
   input  wire logic                   CFG_BAD,
   // Synchronization status.
   input  wire logic                   IFC_SYNC,
   input  wire logic                   TASK_SYNC,
   input  wire logic                   DRIVE_SYNC,
   input  wire logic                   FIELDBUS_PORT_SYNC,
   input  wire logic                   SEND_CYCLE_PULSE,
   // Cycle clock towards task system, drive and fieldbus port.
   output logic                        CYCLE_TICK,
   output logic                        CYCLE_LOCAL,
   // Lamps.
   output logic [`PORT_COUNT-1:0]      LINK_LAMP,
   output logic [`PORT_COUNT-1:0]      TRAFFIC_INDICATOR,
   output logic                        FAULT_LAMP,
   output logic                        SYNC_LAMP,
   // Interrupt.
   output logic                        IRQ
);

   lamp_pkg::lamp_state_t s_q;
   lamp_pkg::lamp_state_t s_d;

   logic                   slow_tick;
   logic                   fast_tick;
   logic [`PORT_COUNT-1:0] busy;

   // Divided enables for the 2 Hz flash and the faster traffic flicker.
   flash_divider #(
      .HALF_CYC (FLASH_HALF_CYC)
   ) u_slow (
      .CLK   (CLK),
      .RST_N (RST_N),
      .TICK  (slow_tick)
   );

   flash_divider #(
      .HALF_CYC (FLICKER_HALF_CYC)
   ) u_fast (
      .CLK   (CLK),
      .RST_N (RST_N),
      .TICK  (fast_tick)
   );

   // One traffic stretcher per port.
   for (genvar p = 0; p < `PORT_COUNT; p++) begin : g_port
      activity_stretch #(
         .HOLD_CYC (STRETCH_CYC)
      ) u_act (
         .CLK    (CLK),
         .RST_N  (RST_N),
         .ACT_IN (RX_ACTIVE[p] | TX_ACTIVE[p]),
         .BUSY   (busy[p])
      );
   end

   // Decoded conditions.
   logic                 bus_fault;
   logic                 dev_fault;
   logic                 ifc_ok;
   logic                 full_sync;
   logic                 addr_ok;
   logic                 rd_stat;
   logic [7:0]           a_ofs;
   logic [`EV_COUNT-1:0] ev;

   // Conditions that the lamps and events are built from.
   always_comb begin
      bus_fault = ~(|PHY_LINK) | ~RATE_OK | ~DUPLEX_OK;
      dev_fault = DEV_FAILED | DEV_UNREACHABLE | CFG_BAD;
      ifc_ok    = s_q.iso_cfg & IFC_SYNC;
      full_sync = ifc_ok & TASK_SYNC & DRIVE_SYNC & FIELDBUS_PORT_SYNC;
      addr_ok   = HSEL & HREADY & HTRANS[1];
      a_ofs     = HADDR[7:0];
      rd_stat   = addr_ok & ~HWRITE & (HADDR[31:8] == 24'h000000) &
                  (a_ofs == `OFS_IRQ_STAT);
      ev = '0;
      ev[`EV_LINK_UP]   = |(PHY_LINK & ~s_q.link_prev);
      ev[`EV_BUS_FAULT] = bus_fault & ~s_q.bus_prev;
      ev[`EV_DEV_FAULT] = dev_fault & ~s_q.dev_prev;
      ev[`EV_SYNC_FULL] = full_sync & ~s_q.full_prev;
      ev[`EV_SYNC_LOST] = ~ifc_ok & s_q.ifc_prev;
   end

   // Next state of the whole block.
   always_comb begin
      s_d = s_q;

      // Bus slave answers with no wait state and always OKAY.
      s_d.hreadyout = 1'b1;

      // Write data phase lands in the register picked during the address phase.
      if (s_q.wr_pend) begin
         unique case (s_q.wr_addr)
            `OFS_CTRL:      s_d.iso_cfg  = HWDATA[`CTRL_ISO_BIT];
            `OFS_CYCLE_LEN: s_d.cyc_len  = HWDATA[15:0];
            `OFS_IRQ_MASK:  s_d.irq_mask = HWDATA[`EV_COUNT-1:0];
            default: ;
         endcase
      end
      s_d.wr_pend = addr_ok & HWRITE;
      s_d.wr_addr = (HADDR[31:8] == 24'h000000) ? a_ofs : 8'hFF;

      // Read data is prepared in the address phase; unmapped words read zero.
      s_d.hrdata = 32'h0000_0000;
      if (addr_ok && !HWRITE && HADDR[31:8] == 24'h000000) begin
         unique case (a_ofs)
            `OFS_CTRL:      s_d.hrdata[`CTRL_ISO_BIT] = s_q.iso_cfg;
            `OFS_CYCLE_LEN: s_d.hrdata[15:0] = s_q.cyc_len;
            `OFS_STATUS: begin
               s_d.hrdata[`PORT_COUNT-1:0]    = s_q.link_lamp;
               s_d.hrdata[`PORT_COUNT+7:8]    = busy;
               s_d.hrdata[16]                 = bus_fault;
               s_d.hrdata[17]                 = dev_fault;
               s_d.hrdata[18]                 = s_q.fault_lamp;
               s_d.hrdata[19]                 = ifc_ok;
               s_d.hrdata[20]                 = full_sync;
               s_d.hrdata[21]                 = s_q.sync_lamp;
               s_d.hrdata[22]                 = s_q.cyc_local;
            end
            `OFS_IRQ_STAT:  s_d.hrdata[`EV_COUNT-1:0] = s_q.irq_stat;
            `OFS_IRQ_MASK:  s_d.hrdata[`EV_COUNT-1:0] = s_q.irq_mask;
            default: ;
         endcase
      end

      // Sticky events; a new event in the clearing read's cycle survives.
      s_d.irq_stat = (rd_stat ? '0 : s_q.irq_stat) | ev;
      s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

      // Edge history for the events.
      s_d.link_prev = PHY_LINK;
      s_d.bus_prev  = bus_fault;
      s_d.dev_prev  = dev_fault;
      s_d.full_prev = full_sync;
      s_d.ifc_prev  = ifc_ok;

      // Flash phases toggle on the divided enables for an even duty.
      if (slow_tick) begin
         s_d.slow_ph = ~s_q.slow_ph;
      end
      if (fast_tick) begin
         s_d.fast_ph = ~s_q.fast_ph;
      end

      // Link lamp follows the physical connection of each port.
      s_d.link_lamp = PHY_LINK;

      // Traffic lamp flickers while stretched traffic is seen.
      s_d.traffic_lamp = busy & {`PORT_COUNT{s_q.fast_ph}};

      // Steady bus fault outranks the flashing device fault; dark when healthy.
      if (bus_fault) begin
         s_d.fault_lamp = 1'b1;
      end else if (dev_fault) begin
         s_d.fault_lamp = s_q.slow_ph;
      end else begin
         s_d.fault_lamp = 1'b0;
      end

      // Sync lamp: steady when all are synchronized, flashing when interface and tasks are, dark otherwise.
      if (full_sync) begin
         s_d.sync_lamp = 1'b1;
      end else if (ifc_ok && TASK_SYNC) begin
         s_d.sync_lamp = s_q.slow_ph;
      end else begin
         s_d.sync_lamp = 1'b0;
      end

      // Cycle clock: none without isochronous mode; the send cycle when synchronized, else a local substitute.
      s_d.cyc_tick  = 1'b0;
      s_d.cyc_local = 1'b0;
      if (!s_q.iso_cfg) begin
         s_d.cyc_cnt = 16'h0000;
      end else if (IFC_SYNC) begin
         s_d.cyc_cnt  = 16'h0000;
         s_d.cyc_tick = SEND_CYCLE_PULSE;
      end else begin
         s_d.cyc_local = 1'b1;
         if (s_q.cyc_cnt >= s_q.cyc_len - 16'h0001) begin
            s_d.cyc_cnt  = 16'h0000;
            s_d.cyc_tick = 1'b1;
         end else begin
            s_d.cyc_cnt = s_q.cyc_cnt + 16'h0001;
         end
      end
   end

   // State register with reset values.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q           <= '0;
         s_q.hreadyout <= 1'b1;
         s_q.iso_cfg   <= `CTRL_RST;
         s_q.cyc_len   <= `CYCLE_LEN_RST;
         s_q.irq_mask  <= `IRQ_MASK_RST;
         s_q.wr_addr   <= 8'hFF;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register, except HRESP, which is tied to OKAY.
   assign HRDATA            = s_q.hrdata;
   assign HREADYOUT         = s_q.hreadyout;
   assign HRESP             = 1'b0;
   assign LINK_LAMP         = s_q.link_lamp;
   assign TRAFFIC_INDICATOR = s_q.traffic_lamp;
   assign FAULT_LAMP        = s_q.fault_lamp;
   assign SYNC_LAMP         = s_q.sync_lamp;
   assign CYCLE_TICK        = s_q.cyc_tick;
   assign CYCLE_LOCAL       = s_q.cyc_local;
   assign IRQ               = s_q.irq;

endmodule : port_status_lamps

/* lamp_monitor.sv */
`timescale 1ns/10ps
`include "lamp_defs.svh"

module lamp_monitor (
   // Clock and reset.
   input wire logic                   CLK,
   input wire logic                   RST_N,
   // Status inputs.
   input wire logic [`PORT_COUNT-1:0] PHY_LINK,
   input wire logic [`PORT_COUNT-1:0] RX_ACTIVE,
   input wire logic [`PORT_COUNT-1:0] TX_ACTIVE,
   input wire logic                   RATE_OK,
   input wire logic                   DUPLEX_OK,
   input wire logic                   DEV_FAILED,
   input wire logic                   DEV_UNREACHABLE,
   input wire logic                   CFG_BAD,
   input wire logic                   IFC_SYNC,
   input wire logic                   TASK_SYNC,
   // Watched outputs.
   input wire logic                   CYCLE_LOCAL,
   input wire logic [`PORT_COUNT-1:0] LINK_LAMP,
   input wire logic [`PORT_COUNT-1:0] TRAFFIC_INDICATOR,
   input wire logic                   FAULT_LAMP,
   input wire logic                   SYNC_LAMP
);
   logic bus_f;
   logic dev_f;
   logic dv_q;
   logic dev_only;

   // Fault causes as seen at the inputs.
   assign bus_f = (PHY_LINK == '0) || !RATE_OK || !DUPLEX_OK;
   assign dev_f = DEV_FAILED || DEV_UNREACHABLE || CFG_BAD;
   assign dev_only = dv_q && dev_f && !bus_f;

   // Remembers a device-only fault out of reset, so the lamp has caught up.
   always_ff @(posedge CLK) begin
      dv_q <= RST_N && dev_f && !bus_f;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   link_follow_a: assert property ($past(RST_N) |-> LINK_LAMP == $past(PHY_LINK))
      else $error("link lamp does not follow the link");
   bus_steady_a: assert property ($past(RST_N) && $past(bus_f) |-> FAULT_LAMP)
      else $error("fault lamp dark on bus fault");
   healthy_dark_a: assert property ($past(RST_N) && $past(!bus_f && !dev_f) |-> !FAULT_LAMP)
      else $error("fault lamp lit while healthy");
   flash_high_a: assert property ((dev_only && FAULT_LAMP)[*8] |=> !FAULT_LAMP)
      else $error("fault flash lit too long");
   flash_low_a: assert property ((dev_only && !FAULT_LAMP)[*8] |=> FAULT_LAMP)
      else $error("fault flash dark too long");
   sync_dark_a: assert property ($past(RST_N) && $past(!IFC_SYNC || !TASK_SYNC) |-> !SYNC_LAMP)
      else $error("sync lamp lit without sync");
   local_clock_a: assert property ($past(RST_N) && CYCLE_LOCAL |-> $past(!IFC_SYNC))
      else $error("local cycle while synchronized");
   traffic_idle_a: assert property
      ((!RX_ACTIVE[0] && !TX_ACTIVE[0])[*8] |=> !TRAFFIC_INDICATOR[0])
      else $error("traffic lamp lit after idle");
endmodule : lamp_monitor

bind port_status_lamps lamp_monitor lamp_monitor_i (
   .CLK(CLK), .RST_N(RST_N), .PHY_LINK(PHY_LINK), .RX_ACTIVE(RX_ACTIVE),
   .TX_ACTIVE(TX_ACTIVE), .RATE_OK(RATE_OK), .DUPLEX_OK(DUPLEX_OK), .DEV_FAILED(DEV_FAILED),
   .DEV_UNREACHABLE(DEV_UNREACHABLE), .CFG_BAD(CFG_BAD), .IFC_SYNC(IFC_SYNC),
   .TASK_SYNC(TASK_SYNC), .CYCLE_LOCAL(CYCLE_LOCAL), .LINK_LAMP(LINK_LAMP),
   .TRAFFIC_INDICATOR(TRAFFIC_INDICATOR), .FAULT_LAMP(FAULT_LAMP), .SYNC_LAMP(SYNC_LAMP)
);

/* lamp_watch.sv */
`timescale 1ns/10ps

module lamp_watch (
   // Clock and count clear.
   input  wire logic        CLK,
   input  wire logic        CLR,
   // Lamp seen by the operator.
   input  wire logic        LAMP,
   // Dark-to-lit changes since the last clear.
   output logic      [15:0] RISES
);
   logic prev_q;

   // Counts each time the lamp lights up, as an eye would.
   always_ff @(posedge CLK) begin
      prev_q <= LAMP;
      if (CLR) begin
         RISES <= 16'h0000;
      end else if (LAMP && !prev_q) begin
         RISES <= RISES + 16'h0001;
      end
   end
endmodule : lamp_watch

/* tb_top.sv */
`timescale 1ns/10ps
`include "lamp_defs.svh"

module tb_top;
   logic                   clk;
   logic                   rst_n;
   logic                   hsel;
   logic                   hwrite;
   logic [1:0]             htrans;
   logic [31:0]            haddr;
   logic [31:0]            hwdata;
   logic [31:0]            hrdata;
   logic                   hready;
   logic                   hresp;
   logic [`PORT_COUNT-1:0] phy;
   logic [`PORT_COUNT-1:0] rx;
   logic [`PORT_COUNT-1:0] tx;
   logic [`PORT_COUNT-1:0] link_l;
   logic [`PORT_COUNT-1:0] traf_l;
   logic                   rate_ok;
   logic                   dup_ok;
   logic [2:0]             dev;
   logic [3:0]             syn;
   logic                   pulse;
   logic                   tick;
   logic                   local_c;
   logic                   fault_l;
   logic                   sync_l;
   logic                   irq;
   logic                   clr;
   logic [15:0]            f_rises;
   logic [15:0]            s_rises;
   int                     n_fail;
   int                     samples_checked;

   // Device under test with short flash, flicker and stretch counts.
   port_status_lamps #(.FLASH_HALF_CYC(8), .FLICKER_HALF_CYC(4), .STRETCH_CYC(6))
   port_status_lamps_i (
      .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .PHY_LINK(phy), .RX_ACTIVE(rx), .TX_ACTIVE(tx),
      .RATE_OK(rate_ok), .DUPLEX_OK(dup_ok), .DEV_FAILED(dev[0]), .DEV_UNREACHABLE(dev[1]),
      .CFG_BAD(dev[2]), .IFC_SYNC(syn[0]), .TASK_SYNC(syn[1]), .DRIVE_SYNC(syn[2]),
      .FIELDBUS_PORT_SYNC(syn[3]), .SEND_CYCLE_PULSE(pulse), .CYCLE_TICK(tick),
      .CYCLE_LOCAL(local_c), .LINK_LAMP(link_l), .TRAFFIC_INDICATOR(traf_l),
      .FAULT_LAMP(fault_l), .SYNC_LAMP(sync_l), .IRQ(irq)
   );

   // Operator eyes on the fault and sync lamps.
   lamp_watch fault_eye_i (.CLK(clk), .CLR(clr), .LAMP(fault_l), .RISES(f_rises));
   lamp_watch sync_eye_i (.CLK(clk), .CLR(clr), .LAMP(sync_l), .RISES(s_rises));

   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Waits, bounded, for an edge with the bus ready.
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
   endtask : wait_ready

   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] x;
      bus(1'b0, a, 32'h00000000, x);
      chk(x & m, e);
   endtask : rdchk

   // Clears the lamp eyes, then lets n edges be counted.
   task automatic watch(input int n);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n + 1) @(posedge clk);
   endtask : watch

   task automatic count_ticks(input int n, input int e);
      int c;
      c = 0;
      repeat (n) begin
         @(posedge clk);
         c += int'(tick === 1'b1);
      end
      chk(c, e);
   endtask : count_ticks

   // Main sequence.
   initial begin
      int seen;
      n_fail = 0;
      samples_checked = 0;
      {hsel, hwrite, htrans, haddr, hwdata, rst_n, rx, tx, pulse, clr} <= '0;
      {phy, rate_ok, dup_ok, dev, syn} <= {2'b11, 2'b11, 3'h0, 4'h0};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(8'h00, 32'h0, 32'hFFFFFFFF);
      rdchk(8'h04, 32'h0C35, 32'hFFFFFFFF);
      rdchk(8'h10, 32'h0, 32'hFFFFFFFF);
      wr(8'h14, 32'hFFFFFFFF);
      rdchk(8'h14, 32'h0, 32'hFFFFFFFF);
      chk(hresp, 1'b0);
      chk({link_l, fault_l}, 3'b110);
      watch(64);
      chk(f_rises, 16'h0);
      // Each bus fault cause, alone and with a device fault, gives a steady lamp.
      for (int i = 0; i < 6; i++) begin
         // A healthy gap first, so that each cause lights the lamp afresh.
         {phy, rate_ok, dup_ok, dev} <= {2'b11, 2'b11, 3'h0};
         repeat (3) @(posedge clk);
         phy <= (i % 3 == 0) ? 2'b00 : 2'b11;
         rate_ok <= (i % 3 != 1);
         dup_ok <= (i % 3 != 2);
         dev <= (i > 2) ? 3'h4 : 3'h0;
         watch(40);
         chk({f_rises, fault_l}, 17'h3);
      end
      {phy, rate_ok, dup_ok, dev} <= {2'b01, 2'b11, 3'h0};
      repeat (3) @(posedge clk);
      chk({link_l, fault_l}, 3'b010);
      // Each device fault cause flashes at the divided rate.
      for (int i = 0; i < 3; i++) begin
         dev <= 3'h1 << i;
         // Let the flash settle so that the window sees whole periods only.
         repeat (2) @(posedge clk);
         watch(64);
         chk(f_rises, 16'h4);
      end
      dev <= 3'h0;
      // Without isochronous mode no sync lamp and no cycle ticks.
      syn <= 4'hF;
      pulse <= 1'b1;
      watch(30);
      chk({s_rises, sync_l}, 17'h0);
      count_ticks(30, 0);
      pulse <= 1'b0;
      wr(8'h00, 32'hFFFFFFFF);
      rdchk(8'h00, 32'h1, 32'hFFFFFFFF);
      watch(30);
      chk({s_rises, sync_l}, 17'h1);
      syn <= 4'h3;
      repeat (2) @(posedge clk);
      watch(64);
      chk(s_rises, 16'h4);
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      @(posedge clk);
      chk({tick, local_c}, 2'b10);
      syn <= 4'hE;
      wr(8'h04, 32'h5);
      repeat (3) @(posedge clk);
      chk({sync_l, local_c}, 2'b01);
      count_ticks(50, 10);
      // A single-cycle burst on each port must still show.
      for (int i = 0; i < 2; i++) begin
         rx <= i ? 2'b00 : 2'b01;
         tx <= i ? 2'b10 : 2'b00;
         @(posedge clk);
         {rx, tx} <= '0;
         seen = 0;
         repeat (12) begin
            @(posedge clk);
            seen |= int'(traf_l[i] === 1'b1);
         end
         chk(seen, 1);
      end
      repeat (20) @(posedge clk);
      chk(traf_l, 2'b00);
      // Bus fault event: masked, then unmasked, cleared by reading status.
      rdchk(8'h0C, 32'h0, 32'h0);
      wr(8'h10, 32'h0);
      rate_ok <= 1'b0;
      repeat (4) @(posedge clk);
      chk(irq, 1'b0);
      rdchk(8'h0C, 32'h2, 32'h2);
      rate_ok <= 1'b1;
      wr(8'h10, 32'h2);
      rdchk(8'h10, 32'h2, 32'hFFFFFFFF);
      rate_ok <= 1'b0;
      repeat (4) @(posedge clk);
      chk(irq, 1'b1);
      rdchk(8'h0C, 32'h2, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      tally_and_finish();
   end
endmodule : tb_top
